/* File: hw/swb_pkg.sv */
package swb_pkg;
	localparam int DATA_W      = 8;
	localparam int ADDR_W      = 6;
	localparam int WDT_W       = 8;
	localparam int PRE_W       = 8;
	localparam int NIB_W       = 4;
	localparam int REG_ADDR_W  = 4;

	localparam logic [ADDR_W-1:0]     FILE_ADDR_MAX  = 6'h3F;
	localparam logic [WDT_W-1:0]      WDT_CLEAR      = 8'h00;
	localparam logic [PRE_W-1:0]      PRE_CLEAR      = 8'h00;
	localparam logic [DATA_W-1:0]     DATA_ZERO      = 8'h00;
	localparam logic                  DEST_WORKING   = 1'b0;
	localparam logic                  DEST_FILE      = 1'b1;
	localparam logic                  EXPIRY_SET     = 1'b1;
	localparam logic                  SLEEP_CLEAR    = 1'b0;
	localparam logic                  SLEEP_RESET    = 1'b1;
	localparam logic [WDT_W-1:0]      COUNT_STEP     = 8'h01;

	// register port map
	localparam logic [REG_ADDR_W-1:0] REG_STATUS     = 4'h0;
	localparam logic [REG_ADDR_W-1:0] REG_MASK       = 4'h1;
	localparam logic [REG_ADDR_W-1:0] REG_FLAGS      = 4'h2;
	localparam logic [REG_ADDR_W-1:0] REG_WDT        = 4'h3;
	localparam logic [REG_ADDR_W-1:0] REG_PRE        = 4'h4;
	localparam logic [REG_ADDR_W-1:0] REG_WORK       = 4'h5;

	// event bit positions
	localparam int EV_SLEEP    = 0;
	localparam int EV_SUB      = 1;
	localparam int EV_BADADDR  = 2;
	localparam int EV_W        = 3;

	// flag bit positions in REG_FLAGS
	localparam int FL_CARRY    = 0;
	localparam int FL_HALF     = 1;
	localparam int FL_ZERO     = 2;
	localparam int FL_SLEEP    = 3;
	localparam int FL_EXPIRY   = 4;
	localparam int FL_ASLEEP   = 5;

	typedef enum logic [1:0] {
		SWB_OP_NONE,
		SWB_OP_SLEEP,
		SWB_OP_SUB
	} swb_op_e;
endpackage : swb_pkg

/* File: hw/swb_sub_alu.sv */
`timescale 1ns/1ps
module swb_sub_alu (
	// operands
	input  wire logic [swb_pkg::DATA_W-1:0] file_val_in,
	input  wire logic [swb_pkg::DATA_W-1:0] work_val_in,
	input  wire logic                       carry_in,
	// result
	output logic      [swb_pkg::DATA_W-1:0] result_out,
	output logic                            carry_out,
	output logic                            half_carry_out,
	output logic                            zero_out
);
	logic [swb_pkg::NIB_W:0]  low_sum;
	logic [swb_pkg::DATA_W:0] full_sum;

	// file + ~work + carry; carry out is the inverted borrow
	always_comb begin
		low_sum  = {1'b0, file_val_in[swb_pkg::NIB_W-1:0]}
			+ {1'b0, ~work_val_in[swb_pkg::NIB_W-1:0]}
			+ {{swb_pkg::NIB_W{1'b0}}, carry_in};
		full_sum = {1'b0, file_val_in} + {1'b0, ~work_val_in}
			+ {{swb_pkg::DATA_W{1'b0}}, carry_in};
		result_out     = full_sum[swb_pkg::DATA_W-1:0];
		carry_out      = full_sum[swb_pkg::DATA_W];
		half_carry_out = low_sum[swb_pkg::NIB_W];
		zero_out       = (result_out == swb_pkg::DATA_ZERO);
	end
endmodule : swb_sub_alu

/* File: hw/swb_regport.sv */
`timescale 1ns/1ps
module swb_regport (
	// clock and reset
	input  wire logic                           core_clk_in,
	input  wire logic                           rst_n_in,
	// bus
	input  wire logic [swb_pkg::REG_ADDR_W-1:0] addr_in,
	input  wire logic [swb_pkg::DATA_W-1:0]     wdata_in,
	input  wire logic                           wr_in,
	input  wire logic                           rd_in,
	output logic      [swb_pkg::DATA_W-1:0]     rdata_out,
	// events and state
	input  wire logic [swb_pkg::EV_W-1:0]       event_in,
	input  wire logic [swb_pkg::DATA_W-1:0]     flags_in,
	input  wire logic [swb_pkg::WDT_W-1:0]      wdt_in,
	input  wire logic [swb_pkg::PRE_W-1:0]      pre_in,
	input  wire logic [swb_pkg::DATA_W-1:0]     work_in,
	output logic                                irq_out
);
	logic [swb_pkg::EV_W-1:0] status_r;
	logic [swb_pkg::EV_W-1:0] mask_r;
	logic                     wr_status;
	logic [swb_pkg::EV_W-1:0] status_nxt;

	assign wr_status  = wr_in && (addr_in == swb_pkg::REG_STATUS);
	assign status_nxt = (status_r & ~(wr_status ? wdata_in[swb_pkg::EV_W-1:0] : '0)) | event_in;

	// set wins over a same-cycle write-one clear
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			status_r <= '0;
		end else begin
			status_r <= status_nxt;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			mask_r <= '0;
		end else if (wr_in && addr_in == swb_pkg::REG_MASK) begin
			mask_r <= wdata_in[swb_pkg::EV_W-1:0];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(status_nxt & mask_r);
		end
	end

	// unmapped addresses read zero
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rdata_out <= swb_pkg::DATA_ZERO;
		end else if (rd_in) begin
			unique case (addr_in)
				swb_pkg::REG_STATUS: rdata_out <= {{(swb_pkg::DATA_W-swb_pkg::EV_W){1'b0}}, status_r};
				swb_pkg::REG_MASK:   rdata_out <= {{(swb_pkg::DATA_W-swb_pkg::EV_W){1'b0}}, mask_r};
				swb_pkg::REG_FLAGS:  rdata_out <= flags_in;
				swb_pkg::REG_WDT:    rdata_out <= wdt_in;
				swb_pkg::REG_PRE:    rdata_out <= pre_in;
				swb_pkg::REG_WORK:   rdata_out <= work_in;
				default:             rdata_out <= swb_pkg::DATA_ZERO;
			endcase
		end else begin
			rdata_out <= swb_pkg::DATA_ZERO;
		end
	end
endmodule : swb_regport

/* File: hw/swb_exec.sv */
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
//Contract
//- sleep halts core, takes one cycle
//- sleep clears watchdog counter and prescaler
//- sleep sets watchdog expiry flag to one
//- sleep clears sleep flag, other flags kept
//- subtract takes 0..63 address, dest bit
//- result is file + ~working + carry
//- dest bit routes the result
//- dest zero working, one file register
module swb_exec (
	// clock and reset
	input  wire logic                           core_clk_in,
	input  wire logic                           rst_n_in,
	// decoded instruction
	input  wire logic                           sleep_op_in,
	input  wire logic                           subtract_with_borrow_op_in,
	input  wire logic [swb_pkg::ADDR_W-1:0]     file_addr_in,
	input  wire logic                           dest_sel_in,
	input  wire logic [swb_pkg::DATA_W-1:0]     file_val_in,
	// watchdog and wake
	input  wire logic                           wdt_tick_in,
	input  wire logic                           pre_tick_in,
	input  wire logic                           wake_in,
	// register port
	input  wire logic [swb_pkg::REG_ADDR_W-1:0] reg_addr_in,
	input  wire logic [swb_pkg::DATA_W-1:0]     reg_wdata_in,
	input  wire logic                           reg_wr_in,
	input  wire logic                           reg_rd_in,
	output logic      [swb_pkg::DATA_W-1:0]     reg_rdata_out,
	output logic                                irq_out,
	// results
	output logic      [swb_pkg::DATA_W-1:0]     working_register_out,
	output logic      [swb_pkg::DATA_W-1:0]     file_wdata_out,
	output logic      [swb_pkg::ADDR_W-1:0]     file_waddr_out,
	output logic                                file_we_out,
	output logic                                carry_flag_out,
	output logic                                half_carry_flag_out,
	output logic                                zero_flag_out,
	output logic                                watchdog_expiry_flag_out,
	output logic                                sleep_entered_flag_out,
	output logic      [swb_pkg::WDT_W-1:0]      wdt_count_out,
	output logic      [swb_pkg::PRE_W-1:0]      wdt_pre_out,
	output logic                                asleep_out
);
	swb_pkg::swb_op_e          op;
	logic [swb_pkg::DATA_W-1:0] alu_res;
	logic                       alu_c;
	logic                       alu_dc;
	logic                       alu_z;
	logic                       addr_ok;
	logic                       do_sub;
	logic                       do_sleep;
	logic [swb_pkg::EV_W-1:0]   events;
	logic [swb_pkg::DATA_W-1:0] flags_vec;
	logic                       work_bus_wr;
	logic                       sub_to_work;
	logic                       sub_to_file;

	// sleep wins over subtract; no instruction runs while asleep
	function automatic swb_pkg::swb_op_e decode_op(
		input logic asleep,
		input logic sleep_req,
		input logic sub_req
	);
		swb_pkg::swb_op_e res;
		res = swb_pkg::SWB_OP_NONE;
		if (!asleep && sleep_req) begin
			res = swb_pkg::SWB_OP_SLEEP;
		end else if (!asleep && sub_req) begin
			res = swb_pkg::SWB_OP_SUB;
		end
		return res;
	endfunction : decode_op

	// shared by watchdog counter and prescaler; wraps at full scale
	function automatic logic [swb_pkg::WDT_W-1:0] count_step(
		input logic [swb_pkg::WDT_W-1:0] cur,
		input logic                      tick
	);
		logic [swb_pkg::WDT_W-1:0] res;
		res = cur;
		if (tick) begin
			res = cur + swb_pkg::COUNT_STEP;
		end
		return res;
	endfunction : count_step

	// register-port write decode
	function automatic logic reg_hit(
		input logic                           wr,
		input logic [swb_pkg::REG_ADDR_W-1:0] addr,
		input logic [swb_pkg::REG_ADDR_W-1:0] target
	);
		return wr && (addr == target);
	endfunction : reg_hit

	// bad address cannot occur with a six-bit field; bit kept in the map
	function automatic logic [swb_pkg::EV_W-1:0] pack_events(
		input logic slept,
		input logic subtracted,
		input logic bad_addr
	);
		logic [swb_pkg::EV_W-1:0] res;
		res                      = '0;
		res[swb_pkg::EV_SLEEP]   = slept;
		res[swb_pkg::EV_SUB]     = subtracted;
		res[swb_pkg::EV_BADADDR] = bad_addr;
		return res;
	endfunction : pack_events

	// read-only flag view
	function automatic logic [swb_pkg::DATA_W-1:0] pack_flags(
		input logic carry,
		input logic half,
		input logic zero,
		input logic sleep_flag,
		input logic expiry_flag,
		input logic asleep
	);
		logic [swb_pkg::DATA_W-1:0] res;
		res                     = swb_pkg::DATA_ZERO;
		res[swb_pkg::FL_CARRY]  = carry;
		res[swb_pkg::FL_HALF]   = half;
		res[swb_pkg::FL_ZERO]   = zero;
		res[swb_pkg::FL_SLEEP]  = sleep_flag;
		res[swb_pkg::FL_EXPIRY] = expiry_flag;
		res[swb_pkg::FL_ASLEEP] = asleep;
		return res;
	endfunction : pack_flags

	// instructions are ignored while asleep; wake or reset resumes
	always_comb begin
		op = decode_op(
			asleep_out,
			sleep_op_in,
			subtract_with_borrow_op_in
		);
	end

	assign addr_ok     = (file_addr_in <= swb_pkg::FILE_ADDR_MAX);
	assign do_sleep    = (op == swb_pkg::SWB_OP_SLEEP);
	assign do_sub      = (op == swb_pkg::SWB_OP_SUB) && addr_ok;
	// a bus write to the working register beats a same-cycle subtract
	assign work_bus_wr = reg_hit(reg_wr_in, reg_addr_in, swb_pkg::REG_WORK);
	assign sub_to_work = do_sub && (dest_sel_in == swb_pkg::DEST_WORKING);
	assign sub_to_file = do_sub && (dest_sel_in == swb_pkg::DEST_FILE);

	swb_sub_alu u_alu (
		.file_val_in    (file_val_in),
		.work_val_in    (working_register_out),
		.carry_in       (carry_flag_out),
		.result_out     (alu_res),
		.carry_out      (alu_c),
		.half_carry_out (alu_dc),
		.zero_out       (alu_z)
	);

	// single-cycle entry into sleep
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			asleep_out <= 1'b0;
		end else if (do_sleep) begin
			asleep_out <= 1'b1;
		end else if (wake_in) begin
			asleep_out <= 1'b0;
		end
	end

	// watchdog counter, cleared by sleep
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			wdt_count_out <= swb_pkg::WDT_CLEAR;
		end else if (do_sleep) begin
			wdt_count_out <= swb_pkg::WDT_CLEAR;
		end else begin
			wdt_count_out <= count_step(wdt_count_out, wdt_tick_in);
		end
	end

	// prescaler, cleared by sleep in the same cycle
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			wdt_pre_out <= swb_pkg::PRE_CLEAR;
		end else if (do_sleep) begin
			wdt_pre_out <= swb_pkg::PRE_CLEAR;
		end else begin
			wdt_pre_out <= count_step(wdt_pre_out, pre_tick_in);
		end
	end

	// active-low expiry bit; reads one after reset
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			watchdog_expiry_flag_out <= swb_pkg::EXPIRY_SET;
		end else if (do_sleep) begin
			watchdog_expiry_flag_out <= swb_pkg::EXPIRY_SET;
		end
	end

	// active-low sleep bit; set only by reset, wake leaves it low
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			sleep_entered_flag_out <= swb_pkg::SLEEP_RESET;
		end else if (do_sleep) begin
			sleep_entered_flag_out <= swb_pkg::SLEEP_CLEAR;
		end
	end

	// arithmetic flags change only on subtract, never on sleep
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			carry_flag_out <= 1'b0;
		end else if (do_sub) begin
			carry_flag_out <= alu_c;
		end
	end

	// nibble carry out of the same addition
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			half_carry_flag_out <= 1'b0;
		end else if (do_sub) begin
			half_carry_flag_out <= alu_dc;
		end
	end

	// zero tests all eight result bits
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			zero_flag_out <= 1'b0;
		end else if (do_sub) begin
			zero_flag_out <= alu_z;
		end
	end

	// destination routing
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			working_register_out <= swb_pkg::DATA_ZERO;
		end else if (work_bus_wr) begin
			working_register_out <= reg_wdata_in;
		end else if (sub_to_work) begin
			working_register_out <= alu_res;
		end
	end

	// file write strobe is a one-cycle pulse
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			file_we_out <= 1'b0;
		end else begin
			file_we_out <= sub_to_file;
		end
	end

	// data and address hold until the next subtract
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			file_wdata_out <= swb_pkg::DATA_ZERO;
			file_waddr_out <= '0;
		end else if (do_sub) begin
			file_wdata_out <= alu_res;
			file_waddr_out <= file_addr_in;
		end
	end

	// status events and the read-only flag view
	always_comb begin
		events    = pack_events(
			do_sleep,
			do_sub,
			(op == swb_pkg::SWB_OP_SUB) && !addr_ok
		);
		flags_vec = pack_flags(
			carry_flag_out,
			half_carry_flag_out,
			zero_flag_out,
			sleep_entered_flag_out,
			watchdog_expiry_flag_out,
			asleep_out
		);
	end

	swb_regport u_regs (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.addr_in     (reg_addr_in),
		.wdata_in    (reg_wdata_in),
		.wr_in       (reg_wr_in),
		.rd_in       (reg_rd_in),
		.rdata_out   (reg_rdata_out),
		.event_in    (events),
		.flags_in    (flags_vec),
		.wdt_in      (wdt_count_out),
		.pre_in      (wdt_pre_out),
		.work_in     (working_register_out),
		.irq_out     (irq_out)
	);
endmodule : swb_exec

/* File: testbench/swb_exec_checker.sv */
`timescale 1ns/1ps
module swb_exec_checker (
	// clock and reset
	input wire logic       core_clk_in,
	input wire logic       rst_n_in,
	// instruction side
	input wire logic       sleep_op_in,
	input wire logic       subtract_with_borrow_op_in,
	input wire logic [5:0] file_addr_in,
	input wire logic       dest_sel_in,
	input wire logic [7:0] file_val_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic       reg_wr_in,
	// results
	input wire logic [7:0] working_register_out,
	input wire logic [7:0] file_wdata_out,
	input wire logic [5:0] file_waddr_out,
	input wire logic       file_we_out,
	input wire logic       carry_flag_out,
	input wire logic       half_carry_flag_out,
	input wire logic       zero_flag_out,
	input wire logic       watchdog_expiry_flag_out,
	input wire logic       sleep_entered_flag_out,
	input wire logic [7:0] wdt_count_out,
	input wire logic [7:0] wdt_pre_out,
	input wire logic       asleep_out
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic       wwr;
	assign sum = file_val_in + {1'b0, ~working_register_out} + carry_flag_out;
	assign nib = file_val_in[3:0] + {1'b0, ~working_register_out[3:0]} + carry_flag_out;
	// a bus write to the working register overrides the subtract result
	assign wwr = reg_wr_in && (reg_addr_in == swb_pkg::REG_WORK);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_sleep;
		sleep_op_in && !asleep_out;
	endsequence
	sequence s_sub;
		subtract_with_borrow_op_in && !sleep_op_in && !asleep_out && !wwr;
	endsequence
	a_sleep_halts: assert property (s_sleep |=> asleep_out)
		else $error("sleep did not halt");
	a_wdt_zeroed: assert property (s_sleep |=> wdt_count_out == 8'h00 && wdt_pre_out == 8'h00)
		else $error("watchdog not cleared");
	a_expiry_set: assert property (s_sleep |=> watchdog_expiry_flag_out)
		else $error("expiry flag not set");
	a_sleep_flags: assert property (s_sleep |=> !sleep_entered_flag_out
		&& $stable(carry_flag_out) && $stable(half_carry_flag_out) && $stable(zero_flag_out))
		else $error("sleep flags wrong");
	a_file_route: assert property (s_sub and dest_sel_in |=> file_we_out
		&& file_waddr_out == $past(file_addr_in) && file_wdata_out == $past(sum[7:0]))
		else $error("file write wrong");
	a_work_route: assert property (s_sub and !dest_sel_in |=> !file_we_out
		&& working_register_out == $past(sum[7:0]))
		else $error("working write wrong");
	a_flags_borrow: assert property (s_sub |=> carry_flag_out == $past(sum[8])
		&& half_carry_flag_out == $past(nib[4]) && zero_flag_out == ($past(sum[7:0]) == 8'h00))
		else $error("arith flags wrong");
	a_asleep_hold: assert property (asleep_out && subtract_with_borrow_op_in && !wwr
		|=> $stable(working_register_out) && !file_we_out)
		else $error("op ran while asleep");
endmodule : swb_exec_checker
bind swb_exec swb_exec_checker u_swb_exec_checker (.*);

/* File: testbench/swb_exec_tb.sv */
`timescale 1ns/1ps
module swb_exec_tb;
	logic       clk, rst_n, slp, sub, dest, wt, pt, wake, rwr, rrd, irq, we;
	logic       c_o, h_o, z_o, e_o, s_o, asl;
	logic [5:0] fa, fwa;
	logic [3:0] ra;
	logic [7:0] fv, rwd, rdat, w_o, fwd, wdt, pre;
	int         fail_count, comparisons, cyc, w, c, h, z, st, mk, se, am, i;
	int         tbl[10] = '{0, 0, 255, 0, 128, 128, 15, 16, 1, 0};
	swb_exec u_swb_exec (
		.core_clk_in(clk), .rst_n_in(rst_n), .sleep_op_in(slp),
		.subtract_with_borrow_op_in(sub), .file_addr_in(fa), .dest_sel_in(dest),
		.file_val_in(fv), .wdt_tick_in(wt), .pre_tick_in(pt), .wake_in(wake),
		.reg_addr_in(ra), .reg_wdata_in(rwd), .reg_wr_in(rwr), .reg_rd_in(rrd),
		.reg_rdata_out(rdat), .irq_out(irq), .working_register_out(w_o),
		.file_wdata_out(fwd), .file_waddr_out(fwa), .file_we_out(we),
		.carry_flag_out(c_o), .half_carry_flag_out(h_o), .zero_flag_out(z_o),
		.watchdog_expiry_flag_out(e_o), .sleep_entered_flag_out(s_o),
		.wdt_count_out(wdt), .wdt_pre_out(pre), .asleep_out(asl));
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	task automatic finish_test();
		if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk);
		ra  <= ad;
		rwd <= d;
		rwr <= 1'b1;
		@(posedge clk);
		rwr <= 1'b0;
		if (ad == swb_pkg::REG_STATUS) st &= ~int'(d);
		if (ad == swb_pkg::REG_MASK) mk = d;
		if (ad == swb_pkg::REG_WORK) w = d;
	endtask : wr
	task automatic rd(input logic [3:0] ad, input int e);
		@(posedge clk);
		ra  <= ad;
		rrd <= 1'b1;
		@(posedge clk);
		rrd <= 1'b0;
		#1 chk("rdata", rdat, e[7:0]);
	endtask : rd
	task automatic op(input logic s_op, input logic [5:0] ad, input logic ds, input logic [7:0] v);
		int s;
		@(posedge clk);
		fa   <= ad;
		dest <= ds;
		fv   <= v;
		sub  <= ~s_op;
		slp  <= s_op;
		@(posedge clk);
		sub <= 1'b0;
		slp <= 1'b0;
		s = v + (~w & 255) + c;
		if (am == 0 && !s_op) begin
			h  = ((v & 15) + (~w & 15) + c) >> 4;
			c  = s >> 8;
			z  = (s & 255) == 0;
			st |= 2;
			if (!ds) w = s & 255;
		end
		#1;
		chk("working", w_o, w[7:0]);
		chk("carry", c_o, c[7:0]);
		chk("half", h_o, h[7:0]);
		chk("zero", z_o, z[7:0]);
		chk("file_we", we, (am == 0 && !s_op) ? ds : 1'b0);
		if (we === 1'b1) chk("file_data", fwd, s[7:0]);
		if (we === 1'b1) chk("file_addr", fwa, ad);
	endtask : op
	initial begin
		{slp, sub, dest, wt, pt, wake, rwr, rrd, fa, ra, fv, rwd} = '0;
		{rst_n, fail_count, comparisons, cyc, w, c, h, z, st, mk, am} = '0;
		se = 1;
		void'($urandom(32'h98a3));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk("expiry", e_o, 1);
		wr(swb_pkg::REG_MASK, 8'h03);
		for (i = 0; i < 10; i += 2) begin
			wr(swb_pkg::REG_WORK, 8'(tbl[i]));
			op(0, 6'h3F, i[1], 8'(tbl[i+1]));
			op(0, 6'h00, 0, 8'(tbl[i+1]));
		end
		for (i = 0; i < 40; i++) begin
			if (i % 5 == 0) wr(swb_pkg::REG_WORK, 8'($urandom));
			op(0, 6'($urandom), 1'($urandom), 8'($urandom));
		end
		rd(swb_pkg::REG_STATUS, st);
		#1 chk("irq", irq, 1);
		wr(swb_pkg::REG_MASK, 8'h00);
		@(posedge clk);
		#1 chk("irq", irq, 0);
		wr(swb_pkg::REG_STATUS, 8'h02);
		wr(swb_pkg::REG_MASK, 8'h03);
		rd(swb_pkg::REG_STATUS, st);
		@(posedge clk);
		wt <= 1'b1;
		pt <= 1'b1;
		repeat (3) @(posedge clk);
		wt <= 1'b0;
		pt <= 1'b0;
		rd(swb_pkg::REG_WDT, 3);
		rd(swb_pkg::REG_PRE, 3);
		op(1, 6'h00, 0, 8'h00);
		am = 1;
		se = 0;
		st |= 1;
		chk("asleep", asl, 1);
		chk("sleep_flag", s_o, 0);
		chk("expiry", e_o, 1);
		chk("wdt", wdt, 0);
		chk("prescaler", pre, 0);
		op(0, 6'h05, 0, 8'h77);
		rd(swb_pkg::REG_FLAGS, (am << 5) | 16 | (se << 3) | (z << 2) | (h << 1) | c);
		rd(swb_pkg::REG_STATUS, st);
		chk("irq", irq, 1);
		rd(4'hF, 0);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		am = 0;
		op(0, 6'h01, 1, 8'h42);
		finish_test();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			finish_test();
		end
	end
endmodule : swb_exec_tb
